// file: hw/fures_pkg.sv
// constants for the flash unlock and row erase sequencer
package fures_pkg;
  localparam int unsigned  CLK_PERIOD_NS = 10;
  localparam int unsigned  ERASE_TIME_NS = 2_000_000;
  localparam int unsigned  ERASE_CYCLES  = ERASE_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned  FORCED_NOPS   = 2;
  localparam logic [7:0]   UNLOCK_KEY1   = 8'h55;
  localparam logic [7:0]   UNLOCK_KEY2   = 8'hAA;
  localparam int unsigned  ROW_LSB       = 5;
  localparam int unsigned  ROW_W         = 10;
  localparam int unsigned  TIMER_W       = 18;
  localparam logic [17:0]  TIMER_RST     = 18'h00000;
  localparam logic [9:0]   ROW_RST       = 10'h000;

  typedef enum logic [1:0] {
    FURES_U_IDLE,
    FURES_U_KEY1,
    FURES_U_ARMED
  } fures_unlock_e;

  typedef enum logic [1:0] {
    FURES_S_IDLE,
    FURES_S_NOP1,
    FURES_S_NOP2,
    FURES_S_BUSY
  } fures_state_e;
endpackage : fures_pkg

// file: hw/fures_top.sv
// flash unlock guard and row erase / program sequencer
`timescale 1ns/100ps
`default_nettype none

module fures_top
  import fures_pkg::*;
#(
  parameter int unsigned ERASE_CYC = fures_pkg::ERASE_CYCLES
)
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic        irq_taken_i,
  input  wire logic        unlock_wr_i,
  input  wire logic [7:0]  unlock_data_i,
  input  wire logic        write_start_set_i,
  input  wire logic        write_enable_bit_i,
  input  wire logic        config_space_select_i,
  input  wire logic        latch_only_load_bit_i,
  input  wire logic        erase_select_i,
  input  wire logic [6:0]  program_address_high_i,
  input  wire logic [7:0]  program_address_low_i,
  output var  logic        write_start_bit_o,
  output var  logic        force_nop_o,
  output var  logic        core_stall_o,
  output var  logic        erase_start_o,
  output var  logic        program_start_o,
  output var  logic        userid_write_o,
  output var  logic        latch_load_o,
  output var  logic [9:0]  row_addr_o
);
  import fures_pkg::*;

  localparam logic [TIMER_W-1:0] STALL_LAST = TIMER_W'(ERASE_CYC - 1);

  fures_unlock_e       unlock_st;
  fures_unlock_e       next_unlock_st;
  fures_state_e        state;
  fures_state_e        next_state;
  logic [TIMER_W-1:0]  timer;
  logic [TIMER_W-1:0]  next_timer;
  logic                long_op;
  logic                next_long_op;
  logic                next_write_start_bit;
  logic                next_force_nop;
  logic                next_core_stall;
  logic                next_erase_start;
  logic                next_program_start;
  logic                next_userid_write;
  logic                next_latch_load;
  logic [ROW_W-1:0]    next_row_addr;
  logic                go;

  // word-select bits dropped so any address in a row names that row
  function automatic logic [ROW_W-1:0] row_of(input logic [6:0] hi, input logic [7:0] lo);
    row_of = {hi, lo[7:ROW_LSB]};
  endfunction : row_of

  // unlock tracker: any other instruction or an interrupt breaks it
  always_comb
  begin
    next_unlock_st = unlock_st;
    if (state != FURES_S_IDLE || irq_taken_i)
    begin
      next_unlock_st = FURES_U_IDLE;
    end
    else if (unlock_wr_i)
    begin
      if (unlock_data_i == UNLOCK_KEY1)
      begin
        next_unlock_st = FURES_U_KEY1;
      end
      else if (unlock_data_i == UNLOCK_KEY2 && unlock_st == FURES_U_KEY1)
      begin
        next_unlock_st = FURES_U_ARMED;
      end
      else
      begin
        next_unlock_st = FURES_U_IDLE;
      end
    end
    else if (instr_valid_i || write_start_set_i)
    begin
      next_unlock_st = FURES_U_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      unlock_st <= FURES_U_IDLE;
    end
    else
    begin
      unlock_st <= next_unlock_st;
    end
  end

  // a write that is refused still forces the nops but starts nothing
  assign go = (unlock_st == FURES_U_ARMED) && !irq_taken_i && write_enable_bit_i;

  always_comb
  begin
    next_state           = state;
    next_timer           = timer;
    next_long_op         = long_op;
    next_write_start_bit = write_start_bit_o;
    next_force_nop       = 1'h0;
    next_core_stall      = 1'h0;
    next_erase_start     = 1'h0;
    next_program_start   = 1'h0;
    next_userid_write    = 1'h0;
    next_latch_load      = 1'h0;
    next_row_addr        = row_addr_o;
    unique case (state)
      FURES_S_IDLE:
      begin
        if (write_start_set_i)
        begin
          next_state           = FURES_S_NOP1;
          next_force_nop       = 1'h1;
          next_write_start_bit = 1'h1;
          next_long_op         = 1'h0;
          if (go)
          begin
            next_row_addr = row_of(program_address_high_i, program_address_low_i);
            if (erase_select_i)
            begin
              // config space erase is not a program memory row erase
              next_erase_start = !config_space_select_i;
              next_long_op     = !config_space_select_i;
            end
            else if (latch_only_load_bit_i)
            begin
              next_latch_load = 1'h1;
            end
            else
            begin
              next_program_start = !config_space_select_i;
              next_userid_write  = config_space_select_i;
              next_long_op       = 1'h1;
            end
          end
        end
      end
      FURES_S_NOP1:
      begin
        next_state     = FURES_S_NOP2;
        next_force_nop = 1'h1;
      end
      FURES_S_NOP2:
      begin
        if (long_op)
        begin
          next_state      = FURES_S_BUSY;
          next_core_stall = 1'h1;
          next_timer      = STALL_LAST;
        end
        else
        begin
          next_state           = FURES_S_IDLE;
          next_write_start_bit = 1'h0;
        end
      end
      FURES_S_BUSY:
      begin
        // only instruction issue halts; clocks never gate here
        if (timer == TIMER_RST)
        begin
          next_state           = FURES_S_IDLE;
          next_write_start_bit = 1'h0;
        end
        else
        begin
          next_timer      = timer - TIMER_W'(1);
          next_core_stall = 1'h1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state             <= FURES_S_IDLE;
      timer             <= TIMER_RST;
      long_op           <= 1'h0;
      write_start_bit_o <= 1'h0;
      force_nop_o       <= 1'h0;
      core_stall_o      <= 1'h0;
      erase_start_o     <= 1'h0;
      program_start_o   <= 1'h0;
      userid_write_o    <= 1'h0;
      latch_load_o      <= 1'h0;
      row_addr_o        <= ROW_RST;
    end
    else
    begin
      state             <= next_state;
      timer             <= next_timer;
      long_op           <= next_long_op;
      write_start_bit_o <= next_write_start_bit;
      force_nop_o       <= next_force_nop;
      core_stall_o      <= next_core_stall;
      erase_start_o     <= next_erase_start;
      program_start_o   <= next_program_start;
      userid_write_o    <= next_userid_write;
      latch_load_o      <= next_latch_load;
      row_addr_o        <= next_row_addr;
    end
  end

  // helper: length of the current stall
  logic [TIMER_W-1:0] stall_len;
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stall_len <= TIMER_RST;
    end
    else
    begin
      stall_len <= core_stall_o ? stall_len + TIMER_W'(1) : TIMER_RST;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence two_nops_s;
    force_nop_o ##1 force_nop_o;
  endsequence

  sequence resume_s;
    !force_nop_o && !core_stall_o;
  endsequence

  logic any_start;
  assign any_start = erase_start_o || program_start_o || latch_load_o || userid_write_o;

  chk_start_needs_unlock: assert property (any_start |-> $past(unlock_st == FURES_U_ARMED) && $past(write_start_set_i))
    else $error("flash operation started without unlock");
  chk_broken_no_start: assert property ((unlock_st != FURES_U_ARMED && state == FURES_S_IDLE) |=> !any_start)
    else $error("flash operation started after broken unlock");
  chk_forced_nops: assert property ((state == FURES_S_IDLE && write_start_set_i) |=> two_nops_s)
    else $error("two forced nops missing");
  chk_latch_no_stall: assert property (latch_load_o |-> two_nops_s ##1 resume_s)
    else $error("latch load stalled or nops wrong");
  chk_erase_setup: assert property (erase_start_o |-> !core_stall_o ##1 !core_stall_o ##1 core_stall_o)
    else $error("erase stall not after two setup cycles");
  chk_stall_length: assert property ($fell(core_stall_o) |-> stall_len == TIMER_W'(ERASE_CYC) && !force_nop_o)
    else $error("stall length wrong");
  chk_write_enable_bit_gate: assert property (any_start |-> $past(write_enable_bit_i))
    else $error("write without write enable");
  chk_erase_row: assert property (erase_start_o |-> row_addr_o == $past({program_address_high_i, program_address_low_i[7:5]}))
    else $error("erase row decode wrong");
  chk_latch_mode: assert property (latch_load_o |-> !program_start_o && $past(latch_only_load_bit_i))
    else $error("latch only mode violated");
  chk_wr_bit_set: assert property ($rose(write_start_bit_o) |-> $past(write_start_set_i))
    else $error("write start bit set by hardware");
  chk_wr_bit_clear: assert property ($fell(write_start_bit_o) |-> !core_stall_o && !force_nop_o)
    else $error("write start bit cleared early");
endmodule : fures_top

`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the flash unlock and row erase sequencer
`timescale 1ns/100ps
`default_nettype none

module tb;
  import fures_pkg::*;
  // short erase time keeps the run brief; every stall expectation derives from it
  localparam int unsigned ERASE_SIM = 8;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        instr_valid_i;
  logic        irq_taken_i;
  logic        unlock_wr_i;
  logic [7:0]  unlock_data_i;
  logic        write_start_set_i;
  logic        write_enable_bit_i;
  logic        config_space_select_i;
  logic        latch_only_load_bit_i;
  logic        erase_select_i;
  logic [6:0]  program_address_high_i;
  logic [7:0]  program_address_low_i;
  logic        write_start_bit_o;
  logic        force_nop_o;
  logic        core_stall_o;
  logic        erase_start_o;
  logic        program_start_o;
  logic        userid_write_o;
  logic        latch_load_o;
  logic [9:0]  row_addr_o;
  int          error_cnt;
  int          num_checks;
  int          cyc;
  int          cnt [6];
  int          base [6];

  fures_top #(.ERASE_CYC(ERASE_SIM)) uut (
    .clk_sys_i              (clk_sys_i),
    .rst_n_i                (rst_n_i),
    .instr_valid_i          (instr_valid_i),
    .irq_taken_i            (irq_taken_i),
    .unlock_wr_i            (unlock_wr_i),
    .unlock_data_i          (unlock_data_i),
    .write_start_set_i      (write_start_set_i),
    .write_enable_bit_i     (write_enable_bit_i),
    .config_space_select_i  (config_space_select_i),
    .latch_only_load_bit_i  (latch_only_load_bit_i),
    .erase_select_i         (erase_select_i),
    .program_address_high_i (program_address_high_i),
    .program_address_low_i  (program_address_low_i),
    .write_start_bit_o      (write_start_bit_o),
    .force_nop_o            (force_nop_o),
    .core_stall_o           (core_stall_o),
    .erase_start_o          (erase_start_o),
    .program_start_o        (program_start_o),
    .userid_write_o         (userid_write_o),
    .latch_load_o           (latch_load_o),
    .row_addr_o             (row_addr_o)
  );

  initial
  begin
    clk_sys_i = 1'h0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // pulses, stall and nop cycles are tallied so each op is judged by exact counts
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (erase_start_o === 1'h1) cnt[0]++;
    if (program_start_o === 1'h1) cnt[1]++;
    if (userid_write_o === 1'h1) cnt[2]++;
    if (latch_load_o === 1'h1) cnt[3]++;
    if (core_stall_o === 1'h1) cnt[4]++;
    if (force_nop_o === 1'h1) cnt[5]++;
    if (cyc == 3000)
    begin
      error_cnt++;
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    num_checks++;
    if (seen !== expd)
    begin
      error_cnt++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, expd);
    end
  endtask : check

  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // one unlock attempt with a gap cycle before the start; exp_p = erase, program, user-ID, latch
  task automatic op(input logic [7:0] key, input logic brk, input logic irq, input logic cfg,
                    input logic latch_only_load_bit, input logic ers, input logic write_enable_bit, input logic [3:0] exp_p,
                    input logic exp_s);
    base = cnt;
    @(posedge clk_sys_i);
    config_space_select_i <= cfg;
    latch_only_load_bit_i <= latch_only_load_bit;
    erase_select_i <= ers;
    write_enable_bit_i <= write_enable_bit;
    unlock_wr_i <= 1'h1;
    unlock_data_i <= key;
    @(posedge clk_sys_i);
    unlock_data_i <= UNLOCK_KEY2;
    @(posedge clk_sys_i);
    unlock_wr_i <= 1'h0;
    instr_valid_i <= brk;
    @(posedge clk_sys_i);
    instr_valid_i <= 1'h0;
    write_start_set_i <= 1'h1;
    irq_taken_i <= irq;
    @(posedge clk_sys_i);
    write_start_set_i <= 1'h0;
    irq_taken_i <= 1'h0;
    #1;
    check(force_nop_o, 1);
    check(write_start_bit_o, 1);
    repeat (2) @(posedge clk_sys_i);
    #1;
    check(force_nop_o, 0);
    check(core_stall_o, exp_s);
    repeat (ERASE_SIM + 2) @(posedge clk_sys_i);
    #1;
    check({write_start_bit_o, core_stall_o}, 0);
    check(cnt[5] - base[5], FORCED_NOPS);
    check(cnt[4] - base[4], exp_s ? ERASE_SIM : 0);
    check({cnt[0] - base[0] == 1, cnt[1] - base[1] == 1, cnt[2] - base[2] == 1, cnt[3] - base[3] == 1}, exp_p);
    check(cnt[0] + cnt[1] + cnt[2] + cnt[3] - base[0] - base[1] - base[2] - base[3], exp_p != 0);
  endtask : op

  initial
  begin
    {error_cnt, num_checks, cyc} = 0;
    cnt = '{default: 0};
    rst_n_i = 1'h0;
    {instr_valid_i, irq_taken_i, unlock_wr_i, write_start_set_i} = 4'h0;
    {write_enable_bit_i, config_space_select_i, latch_only_load_bit_i, erase_select_i} = 4'h0;
    unlock_data_i = 8'h00;
    program_address_high_i = 7'h5A;
    program_address_low_i = 8'hBF;
    repeat (12) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    @(posedge clk_sys_i);
    #1;
    check({write_start_bit_o, force_nop_o, core_stall_o, erase_start_o, program_start_o, userid_write_o,
           latch_load_o, row_addr_o}, 0);
    op(UNLOCK_KEY1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 4'h8, 1'h1);
    check(row_addr_o, {7'h5A, 3'h5});
    op(UNLOCK_KEY1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 4'h1, 1'h0);
    // new row address, word bits set, so the program start must move the row
    @(posedge clk_sys_i);
    program_address_high_i <= 7'h21;
    program_address_low_i <= 8'h5F;
    op(UNLOCK_KEY1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 4'h4, 1'h1);
    check(row_addr_o, {7'h21, 3'h2});
    op(UNLOCK_KEY1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h1, 4'h2, 1'h1);
    // a refused start must leave the row untouched
    @(posedge clk_sys_i);
    program_address_high_i <= 7'h0F;
    program_address_low_i <= 8'hE3;
    op(UNLOCK_KEY1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 4'h0, 1'h0);
    check(row_addr_o, {7'h21, 3'h2});
    op(8'h56, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0, 1'h0);
    op(UNLOCK_KEY1, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1, 4'h0, 1'h0);
    op(UNLOCK_KEY1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 4'h0, 1'h0);
    op(UNLOCK_KEY1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 4'h0, 1'h0);
    wrap_up();
  end
endmodule : tb

`default_nettype wire
